//--- src/irq_pkg.sv
/*
  Shared constants for the upper interrupt status half: register offsets,
  flag positions, reset values, watchdog timing and the watchdog states.
  Assumes a 125 MHz system clock and byte addresses on the register port.
*/
package irq_pkg;

  // register port shape
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register offsets (byte addresses)
  localparam logic [11:0] OFS_INTERRUPT_STATUS = 12'h00c;
  localparam logic [11:0] OFS_INTERRUPT_MASK   = 12'h018;
  localparam logic [11:0] OFS_MAC_CONTROL      = 12'h100;

  // field position of the energy efficient enable in mac_control
  localparam int POS_ENERGY_EFFICIENT_ENABLE = 0;

  // the block holds status bits 31:16; flag index = bit - FLAG_BASE
  localparam int FLAG_BASE = 16;
  localparam int FLAG_W    = 16;

  localparam int POS_NV_WRITE_DONE_FLAG     = 28;
  localparam int POS_TX_IDLE_ENTRY_FLAG     = 26;
  localparam int POS_TX_IDLE_EXIT_FLAG      = 25;
  localparam int POS_RX_IDLE_ENTRY_FLAG     = 24;
  localparam int POS_MAC_RESET_WATCHDOG_FLAG = 23;
  localparam int POS_RX_FIFO_OVERFLOW_FLAG  = 22;
  localparam int POS_TX_ERROR_FLAG          = 21;
  localparam int POS_USB_EVENT_FLAG         = 20;
  localparam int POS_TX_DISABLED_FLAG       = 19;
  localparam int POS_RX_DISABLED_FLAG       = 18;
  localparam int POS_PHY_EVENT_FLAG         = 17;
  localparam int POS_DATA_PORT_DONE_FLAG    = 16;

  // implemented flags (bits 28, 26..16) and the idle flags (26..24)
  localparam logic [15:0] IMPLEMENTED_FLAGS = 16'h17ff;
  localparam logic [15:0] IDLE_FLAGS        = 16'h0700;

  // reset values
  localparam logic [15:0] FLAGS_RESET      = 16'h0000;
  localparam logic [15:0] MASK_RESET       = 16'h0000;
  localparam logic        EEE_ENABLE_RESET = 1'b0;

  // mac reset watchdog: 8 ms at 125 MHz
  localparam int WDOG_TIME_MS    = 8;
  localparam int CLK_FREQ_KHZ    = 125000;
  localparam int WDOG_CYCLES     = WDOG_TIME_MS * CLK_FREQ_KHZ;
  localparam int WDOG_CNT_W      = 20;

  typedef enum logic [1:0] {
    WD_IDLE    = 2'b00,
    WD_COUNT   = 2'b01,
    WD_EXPIRED = 2'b11
  } wdog_state_t;

endpackage

//--- src/wdog_if.sv
/*
  Link between the status block and its mac reset watchdog.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface wdog_if;
  logic reset_req;        // mac reset requested, level
  logic phy_clk_ok;       // phy rx/tx clocks seen, already synchronised
  logic expired;          // one-cycle pulse on timeout
  logic mac_reset_active; // mac reset currently held

  modport ctrl (output reset_req, output phy_clk_ok, input expired, input mac_reset_active);
  modport wdog (input reset_req, input phy_clk_ok, output expired, output mac_reset_active);
endinterface

//--- src/mac_reset_watchdog.sv
/*
  Mac reset watchdog: holds the mac reset while requested and releases it
  once phy clocks are seen or, failing that, after the timeout.
  Assumes phy_clk_ok is synchronised to clk by the instantiating block.
*/
`timescale 1ns/1ps
module mac_reset_watchdog #(
  parameter int CYCLES = irq_pkg::WDOG_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  wdog_if.wdog     wd
);

  localparam logic [irq_pkg::WDOG_CNT_W-1:0] LIMIT = irq_pkg::WDOG_CNT_W'(CYCLES - 1);

  typedef struct packed {
    irq_pkg::wdog_state_t            state;
    logic [irq_pkg::WDOG_CNT_W-1:0]  count;
    logic                            active;
    logic                            expired;
  } wd_reg_t;

  wd_reg_t r;
  wd_reg_t next_r;

  ////////////////////////////////////////////////////////////////////////////
  // next state; the count restarts whenever phy clocks are seen, so a long
  // reset with healthy clocks never trips the timeout
  always_comb begin
    next_r         = r;
    next_r.expired = 1'b0;
    case (r.state)
      irq_pkg::WD_IDLE: begin
        if (wd.reset_req) begin
          next_r.state  = irq_pkg::WD_COUNT;
          next_r.count  = '0;
          next_r.active = 1'b1;
        end
      end
      irq_pkg::WD_COUNT: begin
        if (wd.phy_clk_ok && !wd.reset_req) begin
          next_r.state  = irq_pkg::WD_IDLE;
          next_r.active = 1'b0;
        end else if (wd.phy_clk_ok) begin
          next_r.count = '0;
        end else if (r.count == LIMIT) begin
          next_r.state   = irq_pkg::WD_EXPIRED;
          next_r.expired = 1'b1;
          next_r.active  = 1'b0;                 // release without phy clocks
        end else begin
          next_r.count = r.count + 1'b1;
        end
      end
      irq_pkg::WD_EXPIRED: begin
        if (!wd.reset_req) begin
          next_r.state = irq_pkg::WD_IDLE;
        end
      end
      default: begin
        next_r.state  = irq_pkg::WD_IDLE;
        next_r.active = 1'b0;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '{state: irq_pkg::WD_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign wd.expired          = r.expired;
  assign wd.mac_reset_active = r.active;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_starved_at_limit;
    r.state == irq_pkg::WD_COUNT && r.count == LIMIT && !wd.phy_clk_ok;
  endsequence

  AST_WD_TIMEOUT: assert property (@(posedge clk) disable iff (rst)
    s_starved_at_limit |=> wd.expired ##1 !wd.expired)
    else $error("watchdog did not pulse once at its limit");

  AST_WD_RELEASE: assert property (@(posedge clk) disable iff (rst)
    wd.expired |-> !wd.mac_reset_active && $past(wd.mac_reset_active))
    else $error("mac reset not released on watchdog expiry");

endmodule

//--- src/irq_status_upper_half.sv
/*
  Upper half (bits 31:16) of the interrupt status register, its mask,
  the energy efficient enable, one level interrupt and the mac reset
  watchdog. Event inputs come from units on the same clock; phy_irq and
  phy_clk_present arrive from outside and are synchronised here.
*/
// The strobed register port was left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// - bit 28 follows the level of nonvolatile write completion.
// - bit 26 latches the transmit idle entry pulse.
// - bit 25 latches the transmit idle exit pulse.
// - bit 24 latches the receive idle entry pulse.
// - bits 26..24 read zero while energy efficient enable is clear.
// - 8 ms mac reset watchdog expiry sets bit 23.
// - watchdog expiry releases mac reset without waiting for phy clocks.
// - bit 21 follows the transmitter error level.
// - bit 20 follows the usb status event level until all are cleared.
// - bit 19 stays set while transmit fifo or transmitter is disabled.
// - bit 18 stays set while receive fifo or receiver is disabled.
// - bit 17 follows the phy interrupt level.
// - bit 16 latches the data port completion pulse.
module irq_status_upper_half #(
  parameter int WDOG_CYCLES = irq_pkg::WDOG_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output wire logic [31:0] reg_rdata,
  output wire logic        irq,
  input  wire logic        nv_write_done,
  input  wire logic        tx_idle_entry,
  input  wire logic        tx_idle_exit,
  input  wire logic        rx_idle_entry,
  input  wire logic        mac_reset_req,
  input  wire logic        phy_clk_present,
  output wire logic        mac_reset_active,
  input  wire logic        rx_fifo_write,
  input  wire logic        rx_fifo_full,
  output wire logic        rx_fifo_store,
  input  wire logic        tx_error,
  input  wire logic        usb_status_pending,
  input  wire logic        tx_fifo_disabled,
  input  wire logic        mac_transmit_control_disabled,
  input  wire logic        rx_fifo_disabled,
  input  wire logic        mac_receive_control_disabled,
  input  wire logic        phy_irq,
  input  wire logic        data_port_done
);

  localparam int I_NV   = irq_pkg::POS_NV_WRITE_DONE_FLAG - irq_pkg::FLAG_BASE;
  localparam int I_TXEN = irq_pkg::POS_TX_IDLE_ENTRY_FLAG - irq_pkg::FLAG_BASE;
  localparam int I_TXEX = irq_pkg::POS_TX_IDLE_EXIT_FLAG - irq_pkg::FLAG_BASE;
  localparam int I_RXEN = irq_pkg::POS_RX_IDLE_ENTRY_FLAG - irq_pkg::FLAG_BASE;
  localparam int I_WD   = irq_pkg::POS_MAC_RESET_WATCHDOG_FLAG - irq_pkg::FLAG_BASE;
  localparam int I_OVF  = irq_pkg::POS_RX_FIFO_OVERFLOW_FLAG - irq_pkg::FLAG_BASE;
  localparam int I_TXE  = irq_pkg::POS_TX_ERROR_FLAG - irq_pkg::FLAG_BASE;
  localparam int I_USB  = irq_pkg::POS_USB_EVENT_FLAG - irq_pkg::FLAG_BASE;
  localparam int I_TXD  = irq_pkg::POS_TX_DISABLED_FLAG - irq_pkg::FLAG_BASE;
  localparam int I_RXD  = irq_pkg::POS_RX_DISABLED_FLAG - irq_pkg::FLAG_BASE;
  localparam int I_PHY  = irq_pkg::POS_PHY_EVENT_FLAG - irq_pkg::FLAG_BASE;
  localparam int I_DP   = irq_pkg::POS_DATA_PORT_DONE_FLAG - irq_pkg::FLAG_BASE;

  typedef struct packed {
    logic [15:0] flags;          // status bits 31:16
    logic [15:0] mask;           // mask bits 31:16, same layout
    logic        eee_enable;
    logic [31:0] rdata;
    logic        irq;
    logic        rx_store;
    logic [1:0]  phy_irq_sync;
    logic [1:0]  phy_clk_sync;
  } top_reg_t;

  top_reg_t    r;
  top_reg_t    next_r;
  logic [15:0] src;
  logic [15:0] clr;
  logic        wr_status;
  logic        wr_mask;
  logic        wr_control;
  logic [15:0] clear_req;

  wdog_if wd ();

  ////////////////////////////////////////////////////////////////////////////
  // watchdog hookup; the request is on our clock, phy clocks are synced
  assign wd.reset_req  = mac_reset_req;
  assign wd.phy_clk_ok = r.phy_clk_sync[1];

  mac_reset_watchdog #(
    .CYCLES (WDOG_CYCLES)
  ) u_wdog (
    .clk (clk),
    .rst (rst),
    .wd  (wd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write decode
  always_comb begin
    wr_status  = 1'b0;
    wr_mask    = 1'b0;
    wr_control = 1'b0;
    if (reg_wr && reg_addr == irq_pkg::OFS_INTERRUPT_STATUS) begin
      wr_status = 1'b1;
    end else if (reg_wr && reg_addr == irq_pkg::OFS_INTERRUPT_MASK) begin
      wr_mask = 1'b1;
    end else if (reg_wr && reg_addr == irq_pkg::OFS_MAC_CONTROL) begin
      wr_control = 1'b1;
    end
  end

  // event sources; level sources stay high, so they win back a cleared flag
  always_comb begin
    src        = '0;
    src[I_NV]  = nv_write_done;
    src[I_TXEN] = tx_idle_entry;
    src[I_TXEX] = tx_idle_exit;
    src[I_RXEN] = rx_idle_entry;
    src[I_WD]  = wd.expired;
    src[I_OVF] = rx_fifo_write && rx_fifo_full;
    src[I_TXE] = tx_error;
    src[I_USB] = usb_status_pending;
    src[I_TXD] = tx_fifo_disabled || mac_transmit_control_disabled;
    src[I_RXD] = rx_fifo_disabled || mac_receive_control_disabled;
    src[I_PHY] = r.phy_irq_sync[1];
    src[I_DP]  = data_port_done;
  end

  // write-one-to-clear mask; reserved bits never take part
  assign clr = wr_status ? (reg_wdata[31:16] & irq_pkg::IMPLEMENTED_FLAGS) : '0;

  ////////////////////////////////////////////////////////////////////////////
  // next state of the whole block but the watchdog, which keeps its own
  always_comb begin
    next_r              = r;
    next_r.phy_irq_sync = {r.phy_irq_sync[0], phy_irq};
    next_r.phy_clk_sync = {r.phy_clk_sync[0], phy_clk_present};

    if (wr_control) begin
      next_r.eee_enable = reg_wdata[irq_pkg::POS_ENERGY_EFFICIENT_ENABLE];
    end
    if (wr_mask) begin
      next_r.mask = reg_wdata[31:16] & irq_pkg::IMPLEMENTED_FLAGS;
    end

    // a set in the same cycle as its clear wins, so no event is lost
    next_r.flags = ((r.flags & ~clr) | src) & irq_pkg::IMPLEMENTED_FLAGS;
    if (!next_r.eee_enable) begin
      next_r.flags = next_r.flags & ~irq_pkg::IDLE_FLAGS;
    end

    // full fifo: the write is not passed on and the data is lost
    next_r.rx_store = rx_fifo_write && !rx_fifo_full;

    // read data stands for exactly one cycle after the strobe
    next_r.rdata = '0;
    if (reg_rd && reg_addr == irq_pkg::OFS_INTERRUPT_STATUS) begin
      next_r.rdata = {r.flags, 16'h0000};
    end else if (reg_rd && reg_addr == irq_pkg::OFS_INTERRUPT_MASK) begin
      next_r.rdata = {r.mask, 16'h0000};
    end else if (reg_rd && reg_addr == irq_pkg::OFS_MAC_CONTROL) begin
      next_r.rdata[irq_pkg::POS_ENERGY_EFFICIENT_ENABLE] = r.eee_enable;
    end

    // interrupt from the next flags so it tracks the status it reports
    next_r.irq = |(next_r.flags & next_r.mask);
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '{flags:      irq_pkg::FLAGS_RESET,
             mask:       irq_pkg::MASK_RESET,
             eee_enable: irq_pkg::EEE_ENABLE_RESET,
             default:    '0};
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata        = r.rdata;
  assign irq              = r.irq;
  assign rx_fifo_store    = r.rx_store;
  assign mac_reset_active = wd.mac_reset_active;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // write-one strokes as the bus presents them, kept apart from the clear path
  assign clear_req = wr_status ? reg_wdata[31:16] : 16'h0000;

  sequence s_clear_data_port;
    clear_req[I_DP] && !data_port_done;
  endsequence

  sequence s_status_read;
    reg_rd && reg_addr == irq_pkg::OFS_INTERRUPT_STATUS;
  endsequence

  sequence s_mask_read;
    reg_rd && reg_addr == irq_pkg::OFS_INTERRUPT_MASK;
  endsequence

  AST_NV_LEVEL: assert property (nv_write_done |=> r.flags[I_NV])
    else $error("nonvolatile done level did not set its flag");

  AST_TX_IDLE_ENTRY: assert property (tx_idle_entry ##1 r.eee_enable |-> r.flags[I_TXEN])
    else $error("transmit idle entry pulse lost");

  AST_TX_IDLE_EXIT: assert property (tx_idle_exit ##1 r.eee_enable |-> r.flags[I_TXEX])
    else $error("transmit idle exit pulse lost");

  AST_RX_IDLE_ENTRY: assert property (rx_idle_entry ##1 r.eee_enable |-> r.flags[I_RXEN])
    else $error("receive idle entry pulse lost");

  AST_IDLE_HELD_LOW: assert property (!r.eee_enable |-> (r.flags & irq_pkg::IDLE_FLAGS) == '0)
    else $error("idle flags set while energy efficient enable is clear");

  AST_WATCHDOG_FLAG: assert property (wd.expired |=> r.flags[I_WD])
    else $error("watchdog expiry did not set its flag");

  AST_OVERFLOW: assert property (rx_fifo_write && rx_fifo_full |=> r.flags[I_OVF] && !rx_fifo_store)
    else $error("overflow not flagged or data stored");

  AST_STORE: assert property (rx_fifo_write && !rx_fifo_full |=> rx_fifo_store)
    else $error("write into a non-full fifo was not passed on");

  AST_TX_ERROR: assert property (tx_error |=> r.flags[I_TXE])
    else $error("transmit error did not set its flag");

  AST_USB_LEVEL: assert property (usb_status_pending |=> r.flags[I_USB])
    else $error("usb status level did not hold its flag");

  AST_DISABLED: assert property ((tx_fifo_disabled || mac_transmit_control_disabled) |=> r.flags[I_TXD])
    else $error("transmit disabled flag dropped while disabled");

  AST_RX_DISABLED: assert property ((rx_fifo_disabled || mac_receive_control_disabled) |=> r.flags[I_RXD])
    else $error("receive disabled flag dropped while disabled");

  AST_PHY_SYNC: assert property (phy_irq [*3] |=> r.flags[I_PHY])
    else $error("phy interrupt not reflected after synchroniser");

  AST_DP_LATCH: assert property (
    data_port_done ##1 !(clear_req[I_DP] && !data_port_done) |=> r.flags[I_DP])
    else $error("data port pulse not latched");

  AST_W1C: assert property (s_clear_data_port |=> !r.flags[I_DP])
    else $error("write one did not clear the data port flag");

  AST_RESERVED: assert property (s_status_read |=> reg_rdata[31:29] == 3'h0 && !reg_rdata[27])
    else $error("reserved status bits read nonzero");

  // a level flag written one while its source is quiet must go
  AST_NV_CLEAR: assert property (
    clear_req[I_NV] && !nv_write_done |=> !r.flags[I_NV])
    else $error("nonvolatile flag not cleared by a write of one");

  AST_OVF_CLEAR: assert property (
    clear_req[I_OVF] && !(rx_fifo_write && rx_fifo_full) |=> !r.flags[I_OVF])
    else $error("overflow flag not cleared by a write of one");

  AST_TXE_CLEAR: assert property (
    clear_req[I_TXE] && !tx_error |=> !r.flags[I_TXE])
    else $error("transmit error flag not cleared by a write of one");

  AST_USB_CLEAR: assert property (
    clear_req[I_USB] && !usb_status_pending |=> !r.flags[I_USB])
    else $error("usb flag not cleared by a write of one");

  AST_TXD_CLEAR: assert property (
    clear_req[I_TXD] && !tx_fifo_disabled && !mac_transmit_control_disabled |=> !r.flags[I_TXD])
    else $error("transmit disabled flag not cleared by a write of one");

  AST_RXD_CLEAR: assert property (
    clear_req[I_RXD] && !rx_fifo_disabled && !mac_receive_control_disabled |=> !r.flags[I_RXD])
    else $error("receive disabled flag not cleared by a write of one");

  AST_PHY_CLEAR: assert property (
    clear_req[I_PHY] && !r.phy_irq_sync[1] |=> !r.flags[I_PHY])
    else $error("phy flag not cleared by a write of one");

  // pulse flags have no source to hold them, so the latch alone must
  AST_WD_HELD: assert property (
    r.flags[I_WD] && !clear_req[I_WD] |=> r.flags[I_WD])
    else $error("watchdog flag lost without a clear");

  AST_DP_HELD: assert property (
    r.flags[I_DP] && !clear_req[I_DP] |=> r.flags[I_DP])
    else $error("data port flag lost without a clear");

  // register contents, what the bus and irq show of them, and the fifo store
  AST_RESERVED_ZERO: assert property (
    ((r.flags | r.mask) & ~irq_pkg::IMPLEMENTED_FLAGS) == 16'h0000)
    else $error("reserved flag or mask bit set");

  AST_STATUS_READ: assert property (
    s_status_read |=> reg_rdata == {$past(r.flags), 16'h0000})
    else $error("status read returned wrong data");

  AST_MASK_READ: assert property (
    s_mask_read |=> reg_rdata == {$past(r.mask), 16'h0000})
    else $error("mask read returned wrong data");

  AST_READ_QUIET: assert property (
    !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data shown without a read strobe");

  AST_IRQ_LEVEL: assert property (
    irq == |(r.flags & r.mask))
    else $error("interrupt output does not match unmasked status");

  AST_STORE_IDLE: assert property (
    !rx_fifo_write |=> !rx_fifo_store)
    else $error("fifo store without a write attempt");

endmodule

//--- tb/irq_status_upper_half_tb.sv
/*
  Self-checking bench for the upper interrupt status half: a cycle model of
  flags, mask, enable, read data, irq and fifo store is compared every cycle.
  Assumes the package, watchdog interface and design files compile first.
*/
`timescale 1ns/1ps
module irq_status_upper_half_tb;
  localparam int WD = 20; // short watchdog keeps the run brief
  localparam logic [11:0] STS = irq_pkg::OFS_INTERRUPT_STATUS;
  localparam logic [11:0] MSK = irq_pkg::OFS_INTERRUPT_MASK;
  localparam logic [11:0] CTL = irq_pkg::OFS_MAC_CONTROL;
  logic        clk, rst, reg_wr, reg_rd, irq, mac_reset_req, phy_clk_present;
  logic        mac_reset_active, rx_fifo_write, rx_fifo_full, rx_fifo_store;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d, m_rdata;
  logic [7:0]  lv;
  logic [3:0]  pl;
  logic [15:0] m_flags, m_mask, set, clr;
  logic        m_en, m_store, m_irq, m_s1, m_s2, m_wd;
  int          num_errors, checked, i, n;
  bit          started;

  irq_status_upper_half #(.WDOG_CYCLES(WD)) DUT (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .nv_write_done(lv[0]),
    .tx_idle_entry(pl[0]), .tx_idle_exit(pl[1]), .rx_idle_entry(pl[2]),
    .mac_reset_req(mac_reset_req), .phy_clk_present(phy_clk_present),
    .mac_reset_active(mac_reset_active), .rx_fifo_write(rx_fifo_write),
    .rx_fifo_full(rx_fifo_full), .rx_fifo_store(rx_fifo_store), .tx_error(lv[1]),
    .usb_status_pending(lv[2]), .tx_fifo_disabled(lv[3]), .mac_transmit_control_disabled(lv[4]),
    .rx_fifo_disabled(lv[5]), .mac_receive_control_disabled(lv[6]), .phy_irq(lv[7]),
    .data_port_done(pl[3])
  );

  //////////////////////////////////////////////////////////////////////////////
  // clock and shared tasks
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic compare(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one bus cycle; strobes are never both high
  task automatic op(input logic w, input logic r, input logic [11:0] a, input logic [31:0] v);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
  endtask

  task automatic rd_all();
    op(1'b0, 1'b1, STS, 32'h0);
    op(1'b0, 1'b1, MSK, 32'h0);
    op(1'b0, 1'b1, CTL, 32'h0);
    op(1'b0, 1'b1, 12'h004, 32'h0);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // reference model, advanced on every edge from the inputs before it
  always @(posedge clk) begin
    if (rst) begin
      {m_flags, m_mask, m_en, m_rdata, m_store, m_irq, m_s1, m_s2, m_wd} = '0;
    end else begin
      m_rdata = 32'h0;
      if (reg_rd) begin
        case (reg_addr)
          STS:     m_rdata = {m_flags, 16'h0000};
          MSK:     m_rdata = {m_mask, 16'h0000};
          CTL:     m_rdata = {31'h0, m_en};
          default: m_rdata = 32'h0;
        endcase
      end
      if (reg_wr && reg_addr == MSK) m_mask = reg_wdata[31:16] & irq_pkg::IMPLEMENTED_FLAGS;
      if (reg_wr && reg_addr == CTL) m_en = reg_wdata[0];
      clr = (reg_wr && reg_addr == STS) ? reg_wdata[31:16] : 16'h0;
      set = {3'b000, lv[0], 1'b0, pl[0], pl[1], pl[2], m_wd, rx_fifo_write & rx_fifo_full,
             lv[1], lv[2], lv[3] | lv[4], lv[5] | lv[6], m_s2, pl[3]};
      m_flags = ((m_flags & ~clr) | set) & irq_pkg::IMPLEMENTED_FLAGS;
      if (!m_en) m_flags = m_flags & ~irq_pkg::IDLE_FLAGS;
      m_store = rx_fifo_write & !rx_fifo_full;
      m_s2 = m_s1;
      m_s1 = lv[7];
      m_wd = 1'b0;
      m_irq = |(m_flags & m_mask);
    end
  end

  // every result compared once per cycle, away from the edge
  always @(negedge clk) begin
    if (started) begin
      compare("reg_rdata", m_rdata, reg_rdata);
      compare("irq", {31'h0, m_irq}, {31'h0, irq});
      compare("rx_fifo_store", {31'h0, m_store}, {31'h0, rx_fifo_store});
    end
  end

  // hang guard, far beyond the six hundred or so cycles the sequence needs
  initial begin
    #160000;
    num_errors++;
    stop_test();
  end

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, mac_reset_req, phy_clk_present, rx_fifo_write, rx_fifo_full} = '0;
    reg_addr = 12'h0;
    reg_wdata = 32'h0;
    lv = '0;
    pl = '0;
    started = 1'b0;
    void'($urandom(32'hf96c));
    @(posedge clk);
    started = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_all();
    op(1'b1, 1'b0, 12'h004, 32'hffffffff);
    op(1'b1, 1'b0, MSK, {irq_pkg::IMPLEMENTED_FLAGS, 16'h0});
    op(1'b1, 1'b0, CTL, 32'h1);
    op(1'b1, 1'b0, STS, 32'hffffffff);
    rd_all();
    // each pulse source latches until written one
    for (i = 0; i < 4; i++) begin
      pl[i] <= 1'b1;
      op(1'b0, 1'b1, STS, 32'h0);
      pl <= '0;
      op(1'b0, 1'b1, STS, 32'h0);
      op(1'b0, 1'b1, STS, 32'h0);
      op(1'b1, 1'b0, STS, 32'hffff0000);
      op(1'b0, 1'b1, STS, 32'h0);
    end
    // a pulse landing with its own clear must survive
    pl[3] <= 1'b1;
    op(1'b1, 1'b0, STS, 32'h00010000);
    pl <= '0;
    op(1'b0, 1'b1, STS, 32'h0);
    op(1'b1, 1'b0, STS, 32'h00010000);
    // idle flags vanish when the enable drops and stay dropped
    pl <= 4'h7;
    op(1'b0, 1'b0, STS, 32'h0);
    pl <= '0;
    op(1'b0, 1'b1, STS, 32'h0);
    op(1'b1, 1'b0, CTL, 32'h0);
    op(1'b0, 1'b1, STS, 32'h0);
    pl <= 4'h7;
    op(1'b0, 1'b0, STS, 32'h0);
    pl <= '0;
    op(1'b0, 1'b1, STS, 32'h0);
    op(1'b1, 1'b0, CTL, 32'h1);
    // level sources re-set through a clear until they drop
    for (i = 0; i < 8; i++) begin
      lv[i] <= 1'b1;
      repeat (3) op(1'b0, 1'b0, STS, 32'h0);
      op(1'b0, 1'b1, STS, 32'h0);
      op(1'b1, 1'b0, STS, 32'hffff0000);
      op(1'b0, 1'b1, STS, 32'h0);
      lv[i] <= 1'b0;
      repeat (3) op(1'b0, 1'b0, STS, 32'h0);
      op(1'b1, 1'b0, STS, 32'hffff0000);
      op(1'b0, 1'b1, STS, 32'h0);
    end
    // write into a full fifo is dropped and flagged
    rx_fifo_write <= 1'b1;
    rx_fifo_full <= 1'b1;
    op(1'b0, 1'b1, STS, 32'h0);
    rx_fifo_full <= 1'b0;
    op(1'b0, 1'b1, STS, 32'h0);
    rx_fifo_write <= 1'b0;
    op(1'b1, 1'b0, STS, 32'hffff0000);
    op(1'b0, 1'b1, STS, 32'h0);
    // no phy clocks: the watchdog must give up and release on its own
    mac_reset_req <= 1'b1;
    op(1'b0, 1'b0, STS, 32'h0);
    @(negedge clk);
    compare("mac_reset_active", 32'h1, {31'h0, mac_reset_active});
    for (n = 0; n < 40 && mac_reset_active !== 1'b0; n++) @(negedge clk);
    m_wd = 1'b1;
    compare("watchdog_span", 32'h1, {31'h0, n >= WD - 4 && n <= WD + 4});
    repeat (4) @(negedge clk);
    compare("mac_reset_active", 32'h0, {31'h0, mac_reset_active});
    @(posedge clk);
    mac_reset_req <= 1'b0;
    op(1'b0, 1'b1, STS, 32'h0);
    op(1'b1, 1'b0, STS, 32'h00800000);
    // phy clocks arriving release the reset well before the timeout
    mac_reset_req <= 1'b1;
    repeat (4) op(1'b0, 1'b0, STS, 32'h0);
    @(negedge clk);
    compare("mac_reset_active", 32'h1, {31'h0, mac_reset_active});
    @(posedge clk);
    mac_reset_req <= 1'b0;
    phy_clk_present <= 1'b1;
    for (n = 0; n < 10 && mac_reset_active !== 1'b0; n++) @(negedge clk);
    compare("phy_clock_release", 32'h1, {31'h0, n <= 5});
    repeat (WD) @(posedge clk);
    phy_clk_present <= 1'b0;
    op(1'b0, 1'b1, STS, 32'h0);
    // random traffic on every flag source but the watchdog, and on every register
    for (i = 0; i < 400; i++) begin
      d = $urandom;
      lv <= 8'($urandom);
      pl <= 4'($urandom) & ~pl;
      rx_fifo_write <= 1'($urandom);
      rx_fifo_full <= 1'($urandom);
      case ($urandom % 7)
        0: op(1'b0, 1'b0, STS, d);
        1: op(1'b0, 1'b1, STS, d);
        2: op(1'b0, 1'b1, MSK, d);
        3: op(1'b1, 1'b0, STS, d);
        4: op(1'b1, 1'b0, MSK, d);
        5: op(1'b1, 1'b0, CTL, {31'h0, d[0]});
        default: op(1'b0, 1'b1, 12'h004, d);
      endcase
    end
    lv <= '0;
    pl <= '0;
    rx_fifo_write <= 1'b0;
    repeat (4) op(1'b0, 1'b0, STS, 32'h0);
    // a second reset in mid-run returns everything to zero
    rst <= 1'b1;
    op(1'b0, 1'b0, STS, 32'h0);
    rst <= 1'b0;
    rd_all();
    op(1'b0, 1'b0, STS, 32'h0); // one more cycle so the last read data is compared
    stop_test();
  end
endmodule
